/* File: fsp_host.sv */
// cpu end: axi4-lite command registers driving the sequencer link
//
// Added by the designer: register access over AXI4-Lite and the address map.
module fsp_host (
	input  wire logic        aclk,              // system clock
	input  wire logic        aresetn,           // sync reset, active low
	input  wire logic        awvalid,           // write address valid
	output logic             awready,           // write address ready
	input  wire logic [3:0]  awaddr,            // write byte address
	input  wire logic        wvalid,            // write data valid
	output logic             wready,            // write data ready
	input  wire logic [31:0] wdata,             // write data
	input  wire logic [3:0]  wstrb,             // byte enables
	output logic             bvalid,            // write response valid
	input  wire logic        bready,            // write response ready
	output logic      [1:0]  bresp,             // write response
	input  wire logic        arvalid,           // read address valid
	output logic             arready,           // read address ready
	input  wire logic [3:0]  araddr,            // read byte address
	output logic             rvalid,            // read data valid
	input  wire logic        rready,            // read data ready
	output logic      [31:0] rdata,             // read data
	output logic      [1:0]  rresp,             // read response
	input  wire logic        eeprom_write_busy, // eeprom write running
	output logic             irq_disable,       // interrupts masked
	fsp_if.cpu               bus                // sequencer link
);
	typedef enum logic [2:0] {H_IDLE, H_WAIT_SPM, H_WAIT_EE, H_CTL, H_OP, H_WAIT_RD} fsp_hst_t;

	fsp_hst_t    st_ff;
	logic        aw_ff, w_ff, bvalid_ff, rvalid_ff, blk_ff;
	logic [3:0]  awa_ff;
	logic [31:0] wd_ff, rdata_ff;
	logic [3:0]  ws_ff;
	logic [1:0]  bresp_ff, rresp_ff;
	logic [8:0]  cmd_ff;
	logic [15:0] z_ff, d_ff, zo_ff;
	logic [7:0]  rd_ff;
	logic        do_wr, go;

	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	assign awready = !aw_ff && !bvalid_ff;
	assign wready  = !w_ff && !bvalid_ff;
	assign do_wr   = aw_ff && w_ff;
	assign go      = do_wr && awa_ff == fsp_pkg::REG_CMD && ws_ff[0] && st_ff == H_IDLE;

	// address and data taken in either order, answered one cycle after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff     <= 1'b0;
			w_ff      <= 1'b0;
			awa_ff    <= 4'h0;
			wd_ff     <= 32'h0;
			ws_ff     <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= fsp_pkg::RESP_OK;
		end else begin
			if (awvalid && awready) begin
				aw_ff  <= 1'b1;
				awa_ff <= awaddr;
			end
			if (wvalid && wready) begin
				w_ff  <= 1'b1;
				wd_ff <= wdata;
				ws_ff <= wstrb;
			end
			if (do_wr) begin
				aw_ff     <= 1'b0;
				w_ff      <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff  <= (awa_ff[1:0] != 2'h0) ? fsp_pkg::RESP_ERR : fsp_pkg::RESP_OK;
			end else if (bvalid_ff && bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// command registers; pointer and data are byte-lane writable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_ff <= 9'h000;
			z_ff   <= 16'h0000;
			d_ff   <= 16'h0000;
		end else if (do_wr) begin
			if (go) cmd_ff <= wd_ff[8:0];
			for (int b = 0; b < 2; b++) begin
				if (ws_ff[b] && awa_ff == fsp_pkg::REG_Z) z_ff[8*b +: 8] <= wd_ff[8*b +: 8];
				if (ws_ff[b] && awa_ff == fsp_pkg::REG_DATA) d_ff[8*b +: 8] <= wd_ff[8*b +: 8];
			end
		end
	end

	assign arready = !rvalid_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0;
			rresp_ff  <= fsp_pkg::RESP_OK;
		end else if (arvalid && arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= fsp_pkg::RESP_OK;
			if (araddr == fsp_pkg::REG_CMD) rdata_ff <= {23'h0, cmd_ff};
			else if (araddr == fsp_pkg::REG_Z) rdata_ff <= {16'h0, z_ff};
			else if (araddr == fsp_pkg::REG_DATA) rdata_ff <= {16'h0, d_ff};
			else if (araddr == fsp_pkg::REG_STAT) begin
				rdata_ff <= {8'h0, rd_ff, 6'h0, blk_ff, st_ff != H_IDLE, bus.ctl_rdata};
			end else begin
				rdata_ff <= 32'h0;
				rresp_ff <= fsp_pkg::RESP_ERR;
			end
		end else if (rvalid_ff && rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign bvalid = bvalid_ff;
	assign bresp  = bresp_ff;
	assign rvalid = rvalid_ff;
	assign rdata  = rdata_ff;
	assign rresp  = rresp_ff;

	// ----------------------------------------
	// timed sequence
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= H_IDLE;
			zo_ff <= 16'h0000;
			rd_ff <= 8'h00;
			blk_ff <= 1'b0;
		end else begin
			case (st_ff)
				H_IDLE: if (go) st_ff <= H_WAIT_SPM;
				H_WAIT_SPM: if (!bus.ctl_rdata[fsp_pkg::CTL_EN]) st_ff <= H_WAIT_EE;
				H_WAIT_EE: if (!eeprom_write_busy) st_ff <= H_CTL;
				H_CTL: begin
					st_ff <= H_OP;
					// spm keeps byte bit low; page write keeps word field low
					zo_ff <= cmd_ff[fsp_pkg::CMD_READ] ? z_ff
						: {z_ff[15:6], cmd_ff[fsp_pkg::CTL_WRITE] ? 5'h00 : z_ff[5:1],
						1'b0};
				end
				H_OP: st_ff <= cmd_ff[fsp_pkg::CMD_READ] ? H_WAIT_RD : H_IDLE;
				H_WAIT_RD: if (bus.lpm_valid) begin
					st_ff  <= H_IDLE;
					rd_ff  <= bus.lpm_data;
					blk_ff <= bus.lpm_blocked;
				end
				default: st_ff <= H_IDLE;
			endcase
		end
	end

	// control write then instruction on the next cycle, inside the window
	assign irq_disable   = st_ff == H_WAIT_EE || st_ff == H_CTL || st_ff == H_OP;
	assign bus.ctl_wr    = st_ff == H_CTL;
	assign bus.ctl_wdata = cmd_ff[7:0];
	assign bus.spm       = st_ff == H_OP && !cmd_ff[fsp_pkg::CMD_READ];
	assign bus.lpm       = st_ff == H_OP && cmd_ff[fsp_pkg::CMD_READ];
	assign bus.z_ptr     = zo_ff;
	assign bus.r_data    = d_ff;
endmodule : fsp_host

/* File: fsp_pkg.sv */
// shared constants and decoders for the flash self-programming sequencer
package fsp_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ      = 125_000_000;
	localparam int RC_HZ       = 1_000_000;   // calibrated rc oscillator
	localparam int RC_DIV      = CLK_HZ / RC_HZ;
	localparam int PROG_MIN_US = 3700;
	localparam int PROG_MAX_US = 4500;
	localparam int PROG_TICKS  = int'((64'(PROG_MIN_US) * RC_HZ + 999_999) / 1_000_000);
	localparam int PROG_MAXT   = int'((64'(PROG_MAX_US) * RC_HZ) / 1_000_000);
	localparam int SPM_WINDOW  = 4;           // cycles from control write to spm
	// ----------------------------------------
	// control register layout
	// ----------------------------------------
	localparam int     CTL_EN    = 0;
	localparam int     CTL_ERASE = 1;
	localparam int     CTL_WRITE = 2;
	localparam int     CTL_FUSE  = 3;
	localparam int     CTL_REEN  = 4;
	localparam int     CTL_BUSY  = 6;
	localparam logic [4:0] CTL_RST = 5'h00;
	// ----------------------------------------
	// flash map and pointer fields
	// ----------------------------------------
	localparam int          PC_W      = 12;
	localparam int          WORD_W    = 5;
	localparam int          PAGE_W    = 7;
	localparam int          PAGE_WDS  = 32;
	localparam logic [11:0] RWW_LAST  = 12'hbff;
	localparam logic [11:0] BOOT_128  = 12'hf80;
	localparam logic [11:0] BOOT_256  = 12'hf00;
	localparam logic [11:0] BOOT_512  = 12'he00;
	localparam logic [11:0] BOOT_1K   = 12'hc00;
	localparam logic [15:0] ERASED    = 16'hffff;
	localparam logic [1:0]  FRD_LOW   = 2'h0;
	localparam logic [1:0]  FRD_LOCK  = 2'h1;
	localparam logic [1:0]  FRD_HIGH  = 2'h3;
	// ----------------------------------------
	// host register map
	// ----------------------------------------
	localparam logic [3:0] REG_CMD   = 4'h0;
	localparam logic [3:0] REG_Z     = 4'h4;
	localparam logic [3:0] REG_DATA  = 4'h8;
	localparam logic [3:0] REG_STAT  = 4'hc;
	localparam int         CMD_READ  = 8;
	localparam logic [1:0] RESP_OK   = 2'h0;
	localparam logic [1:0] RESP_ERR  = 2'h2;

	function automatic logic [6:0] z_page(input logic [15:0] z);
		return z[12:6];
	endfunction : z_page

	function automatic logic [4:0] z_word(input logic [15:0] z);
		return z[5:1];
	endfunction : z_word

	function automatic logic [11:0] boot_start(input logic [1:0] sz);
		if (sz == 2'h3) return BOOT_128;
		else if (sz == 2'h2) return BOOT_256;
		else if (sz == 2'h1) return BOOT_512;
		else return BOOT_1K;
	endfunction : boot_start
endpackage : fsp_pkg

/* File: fsp_if.sv */
// link between the cpu end and the flash sequencer
interface fsp_if;
	logic        ctl_wr;      // control register write strobe
	logic [7:0]  ctl_wdata;   // control register write value
	logic [7:0]  ctl_rdata;   // control register read value
	logic        spm;         // store-program-memory strobe
	logic        lpm;         // program-memory load strobe
	logic [15:0] z_ptr;       // pointer
	logic [15:0] r_data;      // r1:r0 word
	logic        lpm_valid;   // load answer
	logic        lpm_blocked; // load hit busy region
	logic [7:0]  lpm_data;    // load byte

	modport dev (input ctl_wr, ctl_wdata, spm, lpm, z_ptr, r_data,
		output ctl_rdata, lpm_valid, lpm_blocked, lpm_data);
	modport cpu (output ctl_wr, ctl_wdata, spm, lpm, z_ptr, r_data,
		input ctl_rdata, lpm_valid, lpm_blocked, lpm_data);
endinterface : fsp_if

/* File: fsp_rc_timer.sv */
// programming timer paced by the rc oscillator tick
module fsp_rc_timer #(
	parameter int RC_DIV = fsp_pkg::RC_DIV,
	parameter int TICKS  = fsp_pkg::PROG_TICKS
) (
	input  wire logic aclk,    // system clock
	input  wire logic aresetn, // sync reset, active low
	input  wire logic start,   // begin one timed access
	output logic      busy,    // access in progress
	output logic      done     // one-cycle end pulse
);
	localparam int DW = $clog2(RC_DIV + 1);
	localparam int CW = $clog2(TICKS + 2);

	if (RC_DIV < 1 || TICKS < 1 || TICKS >= fsp_pkg::PROG_MAXT) begin : g_bad
		$error("fsp_rc_timer: bad divider or tick count");
	end

	logic [DW-1:0] div_ff;
	logic [CW-1:0] cnt_ff;
	logic          busy_ff;
	logic          rc_tick;

	// free running rc tick, independent of the access
	assign rc_tick = (div_ff == DW'(RC_DIV - 1));
	always_ff @(posedge aclk) begin
		// a reset during an access must not stretch it past the maximum
		if ((!aresetn && !busy_ff) || rc_tick) div_ff <= '0;
		else div_ff <= div_ff + 1'b1;
	end

	// one extra tick covers the partial first period, so the minimum holds
	assign done = busy_ff && rc_tick && (cnt_ff == CW'(TICKS));
	assign busy = busy_ff;

	// reset is ignored while an access runs
	always_ff @(posedge aclk) begin
		if (!aresetn && !busy_ff) begin
			busy_ff <= 1'b0;
			cnt_ff  <= '0;
		end else if (start && !busy_ff) begin
			busy_ff <= 1'b1;
			cnt_ff  <= '0;
		end else if (done) begin
			busy_ff <= 1'b0;
		end else if (busy_ff && rc_tick) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end
endmodule : fsp_rc_timer

/* File: fsp_device.sv */
// flash self-programming sequencer, device end

module fsp_device #(
	parameter int PROG_TICKS = fsp_pkg::PROG_TICKS,
	parameter int RC_DIV     = fsp_pkg::RC_DIV
) (
	input  wire logic        aclk,            // system clock
	input  wire logic        aresetn,         // sync reset, active low
	fsp_if.dev               bus,             // cpu link
	input  wire logic [1:0]  boot_size_fuse,  // read-value sense
	input  wire logic [7:0]  fuse_lo_prog,    // 1 = programmed
	input  wire logic [7:0]  fuse_hi_prog,    // 1 = programmed
	input  wire logic [5:0]  lock_prog,       // 1 = programmed
	output logic      [11:0] boot_start_word, // first boot word
	output logic             rww_busy,        // low region unreadable
	output logic             prog_busy        // timed access running
);
	localparam int PW = fsp_pkg::PC_W;

	if (PROG_TICKS < 1 || RC_DIV < 1) begin : g_bad
		$error("fsp_device: bad timing parameters");
	end

	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [15:0] flash_mem [2**PW];
	logic [15:0] page_buf  [fsp_pkg::PAGE_WDS];

	logic [4:0]  ctl_ff;
	logic [2:0]  win_ff;
	logic        rww_busy_ff;
	logic        op_write_ff;
	logic [6:0]  op_page_ff;
	logic [11:0] boot_ff;
	logic        lpm_valid_ff;
	logic        lpm_blk_ff;
	logic [7:0]  lpm_data_ff;
	logic        t_busy;
	logic        t_done;
	logic        win_open;
	logic        cmd_ok;
	logic        start_op;
	logic        fill;
	logic        reen;
	logic        fuse_rd;
	logic [11:0] z_waddr;

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	assign z_waddr  = bus.z_ptr[12:1];
	assign win_open = (win_ff != 3'h0);
	assign cmd_ok   = bus.spm && ctl_ff[fsp_pkg::CTL_EN] && win_open && !t_busy;
	assign start_op = cmd_ok && (ctl_ff[fsp_pkg::CTL_ERASE] || ctl_ff[fsp_pkg::CTL_WRITE]);
	assign fill     = cmd_ok && (ctl_ff[4:1] == 4'h0);
	assign reen     = cmd_ok && ctl_ff[fsp_pkg::CTL_REEN];
	assign fuse_rd  = ctl_ff[fsp_pkg::CTL_FUSE] && ctl_ff[fsp_pkg::CTL_EN] && win_open;

	// ----------------------------------------
	// control register
	// ----------------------------------------
	// writes during a running access are dropped: software polls first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_ff <= fsp_pkg::CTL_RST;
			win_ff <= 3'h0;
		end else if (bus.ctl_wr && !t_busy) begin
			ctl_ff <= bus.ctl_wdata[4:0];
			win_ff <= 3'(fsp_pkg::SPM_WINDOW);
		end else if (bus.spm || (bus.lpm && fuse_rd) || win_ff == 3'h1) begin
			ctl_ff <= fsp_pkg::CTL_RST;
			win_ff <= 3'h0;
		end else if (win_open) begin
			win_ff <= win_ff - 3'h1;
		end
	end

	// enable reads back set until the timed access ends
	assign bus.ctl_rdata = {1'b0, rww_busy_ff, 1'b0, ctl_ff[4:1],
		ctl_ff[fsp_pkg::CTL_EN] | t_busy};

	// ----------------------------------------
	// timed access
	// ----------------------------------------
	fsp_rc_timer #(
		.RC_DIV (RC_DIV),
		.TICKS  (PROG_TICKS)
	) u_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (start_op),
		.busy    (t_busy),
		.done    (t_done)
	);

	// operation target survives a reset while the access runs
	always_ff @(posedge aclk) begin
		if (!aresetn && !t_busy) begin
			op_write_ff <= 1'b0;
			op_page_ff  <= 7'h00;
		end else if (start_op) begin
			op_write_ff <= ctl_ff[fsp_pkg::CTL_WRITE];
			op_page_ff  <= fsp_pkg::z_page(bus.z_ptr);
		end
	end

	// region busy flag: set by erase or write, cleared by re-enable or by a reset while no access runs
	always_ff @(posedge aclk) begin
		if (!aresetn && !t_busy) rww_busy_ff <= 1'b0;
		else if (start_op) rww_busy_ff <= 1'b1;
		else if (reen) rww_busy_ff <= 1'b0;
	end

	// ----------------------------------------
	// flash array and page buffer
	// ----------------------------------------
	// whole page committed in the last cycle; buffer returns to erased after a write
	always_ff @(posedge aclk) begin
		if (fill) page_buf[fsp_pkg::z_word(bus.z_ptr)] <= bus.r_data;
		if (t_done) begin
			for (int i = 0; i < fsp_pkg::PAGE_WDS; i++) begin
				flash_mem[{op_page_ff, 5'(i)}] <= op_write_ff ? page_buf[i]
					: fsp_pkg::ERASED;
				if (op_write_ff) page_buf[i] <= fsp_pkg::ERASED;
			end
		end
	end

	// ----------------------------------------
	// program-memory load
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lpm_valid_ff <= 1'b0;
			lpm_blk_ff   <= 1'b0;
			lpm_data_ff  <= 8'h00;
		end else begin
			lpm_valid_ff <= bus.lpm;
			lpm_blk_ff   <= 1'b0;
			if (bus.lpm) begin
				if (fuse_rd) begin
					// stored as programmed = 1, shown inverted
					if (bus.z_ptr[1:0] == fsp_pkg::FRD_LOW) begin
						lpm_data_ff <= ~fuse_lo_prog;
					end else if (bus.z_ptr[1:0] == fsp_pkg::FRD_LOCK) begin
						lpm_data_ff <= {2'h3, ~lock_prog};
					end else if (bus.z_ptr[1:0] == fsp_pkg::FRD_HIGH) begin
						lpm_data_ff <= ~fuse_hi_prog;
					end else begin
						lpm_data_ff <= 8'hff;
					end
				end else if (rww_busy_ff && z_waddr <= fsp_pkg::RWW_LAST) begin
					lpm_blk_ff  <= 1'b1;
					lpm_data_ff <= 8'hff;
				end else if (bus.z_ptr[0]) begin
					lpm_data_ff <= flash_mem[z_waddr][15:8];
				end else begin
					lpm_data_ff <= flash_mem[z_waddr][7:0];
				end
			end
		end
	end

	assign bus.lpm_valid   = lpm_valid_ff;
	assign bus.lpm_blocked = lpm_blk_ff;
	assign bus.lpm_data    = lpm_data_ff;

	// ----------------------------------------
	// section map
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) boot_ff <= fsp_pkg::BOOT_1K;
		else boot_ff <= fsp_pkg::boot_start(boot_size_fuse);
	end

	assign boot_start_word = boot_ff;
	assign rww_busy        = rww_busy_ff;
	assign prog_busy       = t_busy;
endmodule : fsp_device

/* File: fsp_checker.sv */
// link checker: timing and region rules of the sequencer link
module fsp_checker #(
	parameter int PROG_TICKS = 8, // rc ticks per timed access
	parameter int RC_DIV     = 2  // clocks per rc tick
) (
	input wire logic        aclk,        // system clock
	input wire logic        aresetn,     // sync reset, active low
	input wire logic [7:0]  ctl_rdata,   // control value
	input wire logic        spm,         // store strobe
	input wire logic        lpm,         // load strobe
	input wire logic [15:0] z_ptr,       // pointer
	input wire logic        lpm_valid,   // load answer
	input wire logic        lpm_blocked, // load hit busy region
	input wire logic [7:0]  lpm_data,    // load byte
	input wire logic        prog_busy,   // timed access running
	input wire logic        rww_busy     // low region unreadable
);
	// ----------------------------------------
	// access length
	// ----------------------------------------
	int unsigned busy_len_ff; // cycles of the running access
	// no reset here: an access outlives a reset, so must its count
	always_ff @(posedge aclk) begin
		if (prog_busy)
			busy_len_ff <= busy_len_ff + 1;
		else
			busy_len_ff <= 0;
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	chk_load_answer: assert property (lpm |=> lpm_valid)
		else $error("load strobe got no answer");
	chk_load_origin: assert property (lpm_valid |-> $past(lpm))
		else $error("load answer without a load");
	chk_prog_start: assert property (spm && ctl_rdata[0] && |ctl_rdata[2:1]
		&& !ctl_rdata[3] && !prog_busy |=> prog_busy)
		else $error("erase or write did not start");
	chk_enable_held: assert property (prog_busy |-> ctl_rdata[0])
		else $error("enable bit low while access runs");
	chk_enable_clear: assert property ($fell(prog_busy) |-> !ctl_rdata[0])
		else $error("enable bit still set after access end");
	chk_busy_release: assert property ($fell(rww_busy) |-> $past(spm) && $past(ctl_rdata[4]))
		else $error("region busy flag fell without re-enable");
	chk_region_block: assert property (lpm && rww_busy && !ctl_rdata[3]
		&& z_ptr[12:1] <= fsp_pkg::RWW_LAST |=> lpm_blocked && lpm_data == 8'hff)
		else $error("busy region was readable");
	chk_upper_open: assert property (lpm && !ctl_rdata[3]
		&& z_ptr[12:1] > fsp_pkg::RWW_LAST |=> !lpm_blocked)
		else $error("upper region load blocked");
	chk_lower_open: assert property (lpm && !rww_busy |=> !lpm_blocked)
		else $error("load blocked with region free");
	chk_prog_length: assert property ($fell(prog_busy) |-> busy_len_ff >= PROG_TICKS * RC_DIV
		&& busy_len_ff <= (PROG_TICKS + 1) * RC_DIV)
		else $error("timed access length out of range");
endmodule : fsp_checker

/* File: fsp_tb_top.sv */
// bench: axi host end and sequencer end joined by their link
module fsp_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, eeprom_write_busy, irq_disable;
	logic        rww_busy, prog_busy;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, st;
	logic [1:0]  bresp, rresp, boot_size_fuse, r;
	logic [7:0]  fuse_lo_prog, fuse_hi_prog;
	logic [5:0]  lock_prog;
	logic [11:0] boot_start_word;
	logic [15:0] zp;
	logic [15:0] wbuf [32];
	int          mismatches, samples_checked, seed, p;
	int          cycles = 0;
	fsp_if link();
	fsp_device #(.PROG_TICKS(8), .RC_DIV(2)) i_fsp_device (.aclk, .aresetn, .bus(link),
		.boot_size_fuse, .fuse_lo_prog, .fuse_hi_prog, .lock_prog, .boot_start_word,
		.rww_busy, .prog_busy);
	fsp_host i_fsp_host (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
		.rready, .rdata, .rresp, .eeprom_write_busy, .irq_disable, .bus(link));
	fsp_checker #(.PROG_TICKS(8), .RC_DIV(2)) i_fsp_checker (.aclk, .aresetn,
		.ctl_rdata(link.ctl_rdata), .spm(link.spm), .lpm(link.lpm), .z_ptr(link.z_ptr),
		.lpm_valid(link.lpm_valid), .lpm_blocked(link.lpm_blocked),
		.lpm_data(link.lpm_data), .prog_busy, .rww_busy);
	// clock, and a ceiling well above the few thousand cycles needed
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles++;
		if (cycles > 30000) begin
			mismatches++;
			results();
		end
	end
	// ----------------------------------------
	// tasks and expectations
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask : check
	task automatic results();
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	// ready is looked at on the falling edge, where it has settled
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rs);
		logic ah, wh, an, wn;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= d;
		wstrb   <= 4'hf;
		ah = 1'b0;
		wh = 1'b0;
		while (!(ah && wh)) begin
			@(negedge aclk);
			an = awvalid && awready;
			wn = wvalid && wready;
			@(posedge aclk);
			if (an) awvalid <= 1'b0;
			if (wn) wvalid <= 1'b0;
			ah = ah | an;
			wh = wh | wn;
		end
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			an = bvalid;
			rs = bresp;
			@(posedge aclk);
		end while (!an);
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rs);
		logic hit;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr  <= a;
		do begin
			@(negedge aclk);
			hit = arready;
			@(posedge aclk);
		end while (!hit);
		arvalid <= 1'b0;
		rready  <= 1'b1;
		do begin
			@(negedge aclk);
			hit = rvalid;
			d = rdata;
			rs = rresp;
			@(posedge aclk);
		end while (!hit);
		rready <= 1'b0;
	endtask : rd
	// one command, then poll until sequence and access are over
	task automatic op(input logic [8:0] c, input logic [15:0] z, input logic [15:0] d);
		wr(fsp_pkg::REG_Z, {16'h0, z}, r);
		wr(fsp_pkg::REG_DATA, {16'h0, d}, r);
		wr(fsp_pkg::REG_CMD, {23'h0, c}, r);
		check(32'(r), 32'(fsp_pkg::RESP_OK));
		do rd(fsp_pkg::REG_STAT, st, r); while (st[8] || st[0]);
	endtask : op
	task automatic ld(input logic [7:0] c, input logic [15:0] z, input logic [8:0] exp);
		op({1'b1, c}, z, 16'h0);
		check(32'({st[9], st[23:16]}), 32'(exp));
	endtask : ld
	function automatic logic [11:0] boot_exp(input logic [1:0] sz);
		case (sz)
			2'h3: return 12'hf80;
			2'h2: return 12'hf00;
			2'h1: return 12'he00;
			default: return 12'hc00;
		endcase
	endfunction : boot_exp
	function automatic logic [7:0] fuse_exp(input logic [1:0] sel);
		case (sel)
			2'h0: return ~fuse_lo_prog;
			2'h1: return {2'b11, ~lock_prog};
			2'h2: return 8'hff;
			default: return ~fuse_hi_prog;
		endcase
	endfunction : fuse_exp
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		seed = 32'hf30754ef;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, eeprom_write_busy} = 7'h0;
		{awaddr, araddr, wstrb, wdata, boot_size_fuse} = 46'h0;
		fuse_lo_prog = 8'($random(seed));
		fuse_hi_prog = 8'($random(seed));
		lock_prog = 6'($random(seed));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(fsp_pkg::REG_STAT, st, r);
		check(st, 32'h0);
		rd(4'h6, st, r);
		check({st[29:0], r}, 32'(fsp_pkg::RESP_ERR));
		for (int i = 0; i < 4; i++) begin
			boot_size_fuse <= 2'(i);
			repeat (3) @(posedge aclk);
			check(32'(boot_start_word), 32'(boot_exp(2'(i))));
		end
		for (int i = 0; i < 4; i++)
			ld(8'h09, 16'(i), {1'b0, fuse_exp(2'(i))});
		// erase held back by a busy eeprom, interrupts masked meanwhile
		p = ($random(seed) & 32'h7fffffff) % 96;
		zp = {3'($random(seed)), 7'(p), 6'h0};
		eeprom_write_busy <= 1'b1;
		wr(fsp_pkg::REG_Z, {16'h0, zp}, r);
		wr(fsp_pkg::REG_CMD, 32'h003, r);
		repeat (20) @(posedge aclk);
		check(32'({irq_disable, prog_busy}), 32'h2);
		eeprom_write_busy <= 1'b0;
		while (!prog_busy) @(posedge aclk);
		rd(fsp_pkg::REG_STAT, st, r);
		check(32'({st[6], st[0]}), 32'h3);
		do rd(fsp_pkg::REG_STAT, st, r); while (st[8] || st[0]);
		check(32'(irq_disable), 32'h0);
		ld(8'h01, zp, 9'h1ff);
		op(9'h000, 16'h1ffe, 16'h0);
		op({1'b1, 8'h01}, 16'h1ffe, 16'h0);
		check(32'(st[9]), 32'h0);
		op(9'h011, zp, 16'h0);
		ld(8'h01, zp | 16'h3, 9'h0ff);
		// fill buffer, write page, read both bytes of every word
		for (int w = 0; w < 32; w++) begin
			wbuf[w] = 16'($random(seed));
			op(9'h001, zp | 16'(w << 1), wbuf[w]);
		end
		op(9'h005, zp, 16'h0);
		op(9'h011, zp, 16'h0);
		for (int w = 0; w < 32; w++) begin
			ld(8'h01, zp | 16'(w << 1), {1'b0, wbuf[w][7:0]});
			ld(8'h01, zp | 16'(w << 1) | 16'h1, {1'b0, wbuf[w][15:8]});
		end
		// reset in mid-erase must not cut the access short
		wr(fsp_pkg::REG_Z, {16'h0, zp}, r);
		wr(fsp_pkg::REG_CMD, 32'h003, r);
		while (!prog_busy) @(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		check(32'(prog_busy), 32'h1);
		do rd(fsp_pkg::REG_STAT, st, r); while (st[0]);
		op(9'h011, zp, 16'h0);
		ld(8'h01, zp, 9'h0ff);
		results();
	end
endmodule : fsp_tb_top
